// File: rtl/dpm_core.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// - Mode code 1101 selects high-speed reverse
// - First loop enable gates first clock
// - Second loop enable gates second clock
// - First select decodes M 1,2,4,8
// - Second select decodes M likewise
// - High-speed output runs M times 2.048MHz
// - Driver enables for frame, first, second
// - Forward/slave gives L times 56k/64k
// - First select holds L minus one
// - Second select holds L minus one
// - Zero first select gives 64kHz in forward 64k mode
// - Five 5-bit registers at 0x00-0x04
// - High-speed mode ignores strap, M limited
module dpm_core #(
   parameter int unsigned REF_TIMEOUT_CYC = dpm_pkg::REF_TIMEOUT_CYC
) (
   input  wire logic clk_sys_i,
   input  wire logic reset_i,
   input  wire logic ser_clk_i,
   input  wire logic ser_data_i,
   input  wire logic ser_select_n_i,
   input  wire logic reference_clock_in_i,
   input  wire logic master_strap_i,
   output logic      ser_data_o,
   output logic      ser_data_oe_o,
   output logic      first_clock_out_o,
   output logic      first_clock_oe_o,
   output logic      second_clock_out_o,
   output logic      second_clock_oe_o,
   output logic      frame_pulse_o,
   output logic      frame_pulse_oe_o,
   output logic      lock_indication_out_o
);

   localparam int unsigned TW = $clog2(REF_TIMEOUT_CYC + 1);

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   if (REF_TIMEOUT_CYC < 2) begin : g_bad_timeout
      $error("REF_TIMEOUT_CYC must be at least 2");
   end

   logic [4:0]          pin_meta;
   logic [4:0]          pin_sync;
   logic [4:0]          pin_last;
   logic                sclk_rise;
   logic                sclk_fall;
   logic                sel_act;
   logic                sdi;
   logic                ref_rise;
   logic                strap_master;
   dpm_pkg::dpm_state_e state;
   logic [2:0]          bit_cnt;
   logic [7:0]          cmd_sr;
   logic [7:0]          data_sr;
   logic [7:0]          rd_sr;
   logic [7:0]          next_cmd;
   logic                commit_wr;
   logic [4:0]          cfg [dpm_pkg::NUM_REGS];
   logic [3:0]          mode_code;
   logic                hs_mode;
   logic                fwd64_mode;
   logic                fwd56_mode;
   logic                run_first;
   logic                run_second;
   logic [5:0]          ratio_first;
   logic [5:0]          ratio_second;
   logic [31:0]         word_first;
   logic [31:0]         word_second;
   logic [TW-1:0]       ref_cnt;
   logic                ref_alive;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // Output ratio from a select field: M in high-speed, else sel+1
   function automatic logic [5:0] sel_ratio(input logic hs, input logic [4:0] sel);
      logic [5:0] r;
      r = 6'(sel) + 6'h01;
      if (hs) begin
         casez (sel)
            5'b0000?: r = 6'h01;
            5'b0001?: r = 6'h02;
            5'b001??: r = 6'h04;
            default:  r = 6'h08;
         endcase
      end
      return r;
   endfunction

   // Tuning word from base rate and ratio
   function automatic logic [31:0] tune_word(input logic hs, input logic f56,
                                             input logic [5:0] ratio);
      logic [31:0] base;
      base = hs ? dpm_pkg::WORD_HS : (f56 ? dpm_pkg::WORD_56K : dpm_pkg::WORD_64K);
      return 32'(base * ratio);
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers: {strap, reference, select_n, data, clock}
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         pin_meta <= dpm_pkg::PIN_RESET;
         pin_sync <= dpm_pkg::PIN_RESET;
         pin_last <= dpm_pkg::PIN_RESET;
      end else begin
         pin_meta <= {master_strap_i, reference_clock_in_i, ser_select_n_i, ser_data_i, ser_clk_i};
         pin_sync <= pin_meta;
         pin_last <= pin_sync;
      end
   end

   assign sclk_rise    = pin_sync[0] & ~pin_last[0];
   assign sclk_fall    = ~pin_sync[0] & pin_last[0];
   assign sdi          = pin_sync[1];
   assign sel_act      = ~pin_sync[2];
   assign ref_rise     = pin_sync[3] & ~pin_last[3];
   assign strap_master = pin_sync[4];

   // ----------------------------------------------------------------
   // Serial control port
   // ----------------------------------------------------------------
   assign next_cmd  = {cmd_sr[6:0], sdi};
   assign commit_wr = (state == dpm_pkg::ST_DATA) && sclk_rise && (bit_cnt == dpm_pkg::LAST_BIT_IDX)
                      && !cmd_sr[7] && (cmd_sr[6:0] < 7'(dpm_pkg::NUM_REGS));

   // Frame sequencer: direction, address, then data
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || !sel_act) begin
         state   <= dpm_pkg::ST_IDLE;
         bit_cnt <= 3'h0;
         cmd_sr  <= 8'h00;
         data_sr <= 8'h00;
      end else begin
         unique case (state)
            dpm_pkg::ST_IDLE: begin
               state <= dpm_pkg::ST_CMD;
            end
            dpm_pkg::ST_CMD: begin
               if (sclk_rise) begin
                  cmd_sr  <= next_cmd;
                  bit_cnt <= bit_cnt + 3'h1;
                  if (bit_cnt == dpm_pkg::LAST_BIT_IDX) begin
                     state <= dpm_pkg::ST_DATA;
                  end
               end
            end
            dpm_pkg::ST_DATA: begin
               if (sclk_rise) begin
                  data_sr <= {data_sr[6:0], sdi};
                  bit_cnt <= bit_cnt + 3'h1;
                  if (bit_cnt == dpm_pkg::LAST_BIT_IDX) begin
                     state <= dpm_pkg::ST_HOLD;
                  end
               end
            end
            dpm_pkg::ST_HOLD: begin
               state <= dpm_pkg::ST_HOLD;
            end
         endcase
      end
   end

   // Read shift register, loaded at end of address, shifted on falling clock
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         rd_sr      <= 8'h00;
         ser_data_o <= 1'b0;
      end else if (state == dpm_pkg::ST_CMD && sclk_rise && bit_cnt == dpm_pkg::LAST_BIT_IDX) begin
         rd_sr <= (next_cmd[6:0] < 7'(dpm_pkg::NUM_REGS)) ? {3'h0, cfg[next_cmd[2:0]]} : 8'h00;
      end else if (state == dpm_pkg::ST_DATA && sclk_fall) begin
         ser_data_o <= rd_sr[7];
         rd_sr      <= {rd_sr[6:0], 1'b0};
      end
   end

   assign ser_data_oe_o = (state == dpm_pkg::ST_DATA) && cmd_sr[7];

   // Command registers hold the last write and act next cycle
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         for (int i = 0; i < dpm_pkg::NUM_REGS; i++) begin
            cfg[i] <= dpm_pkg::REG_RESET;
         end
      end else if (commit_wr) begin
         cfg[cmd_sr[2:0]] <= {data_sr[3:0], sdi};
      end
   end

   // ----------------------------------------------------------------
   // Mode and synthesis decode
   // ----------------------------------------------------------------
   assign mode_code  = cfg[0][dpm_pkg::MODE_MSB:dpm_pkg::MODE_LSB];
   assign hs_mode    = (mode_code == dpm_pkg::MODE_HS_REVERSE);
   assign fwd64_mode = (mode_code == dpm_pkg::MODE_FWD_64K);
   assign fwd56_mode = (mode_code == dpm_pkg::MODE_FWD_56K);
   // High-speed ignores the strap; forward/slave needs slave strap
   assign run_first  = cfg[0][dpm_pkg::LOOP_EN_BIT]
                       & (hs_mode | ((fwd64_mode | fwd56_mode) & ~strap_master));
   assign run_second = cfg[1][dpm_pkg::LOOP_EN_BIT]
                       & (hs_mode | ((fwd64_mode | fwd56_mode) & ~strap_master));

   // Ratios and tuning words, registered
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         ratio_first  <= dpm_pkg::RATIO_RESET;
         ratio_second <= dpm_pkg::RATIO_RESET;
         word_first   <= '0;
         word_second  <= '0;
      end else begin
         ratio_first  <= sel_ratio(hs_mode, cfg[2]);
         ratio_second <= sel_ratio(hs_mode, cfg[3]);
         word_first   <= tune_word(hs_mode, fwd56_mode, sel_ratio(hs_mode, cfg[2]));
         word_second  <= tune_word(hs_mode, fwd56_mode, sel_ratio(hs_mode, cfg[3]));
      end
   end

   // ----------------------------------------------------------------
   // Synthesizers
   // ----------------------------------------------------------------
   dpm_nco #(.W(dpm_pkg::NCO_W)) u_first (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .run_i     (run_first),
      .word_i    (word_first),
      .clk_o     (first_clock_out_o)
   );

   dpm_nco #(.W(dpm_pkg::NCO_W)) u_second (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .run_i     (run_second),
      .word_i    (word_second),
      .clk_o     (second_clock_out_o)
   );

   // Output driver enables straight from the register
   assign frame_pulse_oe_o  = cfg[4][dpm_pkg::FRAME_DRV_BIT];
   assign first_clock_oe_o  = cfg[4][dpm_pkg::FIRST_DRV_BIT];
   assign second_clock_oe_o = cfg[4][dpm_pkg::SECOND_DRV_BIT];

   // ----------------------------------------------------------------
   // Reference watch, frame pulse and lock indication
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         ref_cnt   <= '0;
         ref_alive <= 1'b0;
      end else if (ref_rise) begin
         ref_cnt   <= '0;
         ref_alive <= 1'b1;
      end else if (ref_cnt == TW'(REF_TIMEOUT_CYC - 1)) begin
         ref_alive <= 1'b0;
      end else begin
         ref_cnt <= ref_cnt + TW'(1);
      end
   end

   // Buffered reference as frame pulse; lock while reference alive and a running loop has detection enabled
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         frame_pulse_o         <= 1'b0;
         lock_indication_out_o <= 1'b0;
      end else begin
         frame_pulse_o         <= pin_sync[3];
         lock_indication_out_o <= ref_alive
            & ((run_first & ~cfg[4][dpm_pkg::FIRST_LDD_BIT])
             | (run_second & ~cfg[4][dpm_pkg::SECOND_LDD_BIT]));
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   chk_hs_mode_decode: assert property (hs_mode |-> run_first == cfg[0][0] && run_second == cfg[1][0])
      else $error("high-speed loops do not follow enables");
   chk_first_loop_gate: assert property (!cfg[0][0] ##1 !cfg[0][0] |-> !first_clock_out_o)
      else $error("first clock runs while loop disabled");
   chk_second_loop_gate: assert property (!cfg[1][0] ##1 !cfg[1][0] |-> !second_clock_out_o)
      else $error("second clock runs while loop disabled");
   chk_first_m_eight: assert property (hs_mode && cfg[2][4:3] != 2'h0 && $stable(cfg[2])
                                       |=> ratio_first == 6'h08)
      else $error("first M not eight");
   chk_second_m_decode: assert property (hs_mode && cfg[3][4:1] == 4'h1 && $stable(cfg[3])
                                         |=> ratio_second == 6'h02)
      else $error("second M not two");
   chk_hs_word: assert property (hs_mode && $stable(cfg[2]) |=> word_first == 32'(dpm_pkg::WORD_HS * ratio_first))
      else $error("high-speed tuning word wrong");
   chk_drive_enables: assert property (commit_wr && cmd_sr[2:0] == 3'h4
                                       |=> {frame_pulse_oe_o, first_clock_oe_o, second_clock_oe_o} == $past(data_sr[3:1]))
      else $error("driver enables do not follow register");
   chk_fwd_ratio: assert property (fwd64_mode && $stable(cfg[3]) |=> ratio_second == 6'($past(cfg[3])) + 6'h01)
      else $error("forward ratio not sel plus one");
   chk_zero_sel_64k: assert property (fwd64_mode && cfg[2] == 5'h00 && $stable(cfg[2])
                                      |=> word_first == dpm_pkg::WORD_64K)
      else $error("zero select not 64kHz");
   chk_write_commit: assert property (commit_wr |=> cfg[$past(cmd_sr[2:0])] == $past({data_sr[3:0], sdi}))
      else $error("write not committed");
   chk_lock_disable: assert property (cfg[4][1:0] == 2'h3 |=> !lock_indication_out_o)
      else $error("lock shown with detection disabled");
   chk_strap_slave: assert property (strap_master && fwd64_mode |-> !run_first && !run_second)
      else $error("forward mode runs with master strap");

   cov_hs_write: cover property (commit_wr && cmd_sr[2:0] == 3'h0);
   cov_read_frame: cover property (state == dpm_pkg::ST_DATA && ser_data_oe_o ##1 state == dpm_pkg::ST_HOLD);
   cov_hs_running: cover property (hs_mode && run_first && run_second);
   cov_lock: cover property ($rose(lock_indication_out_o));

endmodule
`default_nettype wire

// File: pkg/dpm_pkg.sv
`default_nettype none
package dpm_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int unsigned REG_W     = 5;
   localparam int unsigned ADDR_W    = 7;
   localparam int unsigned NUM_REGS  = 5;
   localparam logic [6:0]  OFF_MODE_LOOP1   = 7'h00;  // mode_and_first_loop_enable
   localparam logic [6:0]  OFF_MULT_LOOP2   = 7'h01;  // multiplier_and_second_loop_enable
   localparam logic [6:0]  OFF_FIRST_SEL    = 7'h02;  // first_output_synth_select
   localparam logic [6:0]  OFF_SECOND_SEL   = 7'h03;  // second_output_synth_select
   localparam logic [6:0]  OFF_DRIVE_EN     = 7'h04;  // output_driver_enables
   localparam logic [4:0]  REG_RESET        = 5'h00;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int unsigned LOOP_EN_BIT      = 0;
   localparam int unsigned MODE_MSB         = 4;
   localparam int unsigned MODE_LSB         = 1;
   localparam int unsigned FRAME_DRV_BIT    = 4;
   localparam int unsigned FIRST_DRV_BIT    = 3;
   localparam int unsigned SECOND_DRV_BIT   = 2;
   localparam int unsigned SECOND_LDD_BIT   = 1;
   localparam int unsigned FIRST_LDD_BIT    = 0;

   // ----------------------------------------------------------------
   // Mode codes
   // ----------------------------------------------------------------
   localparam logic [3:0]  MODE_HS_REVERSE  = 4'hD;
   localparam logic [3:0]  MODE_FWD_64K     = 4'h6;
   localparam logic [3:0]  MODE_FWD_56K     = 4'h7;

   // ----------------------------------------------------------------
   // Serial frame: 1 direction bit, 7 address bits, 8 data bits
   // ----------------------------------------------------------------
   localparam logic [2:0]  LAST_BIT_IDX     = 3'h7;
   localparam logic [4:0]  PIN_RESET        = 5'h04;  // Select idle high
   localparam logic [5:0]  RATIO_RESET      = 6'h01;

   // ----------------------------------------------------------------
   // Clock rates and synthesizer tuning words
   // ----------------------------------------------------------------
   localparam longint unsigned CLK_HZ       = 100_000_000;
   localparam longint unsigned BASE_HS_HZ   = 2_048_000;
   localparam longint unsigned BASE_64K_HZ  = 64_000;
   localparam longint unsigned BASE_56K_HZ  = 56_000;
   localparam int unsigned     NCO_W        = 32;
   localparam logic [31:0] WORD_HS  = 32'((BASE_HS_HZ  << 32) / CLK_HZ);
   localparam logic [31:0] WORD_64K = 32'((BASE_64K_HZ << 32) / CLK_HZ);
   localparam logic [31:0] WORD_56K = 32'((BASE_56K_HZ << 32) / CLK_HZ);

   // ----------------------------------------------------------------
   // Reference activity timeout
   // ----------------------------------------------------------------
   localparam int unsigned REF_TIMEOUT_US   = 250;
   localparam int unsigned REF_TIMEOUT_CYC  = REF_TIMEOUT_US * int'(CLK_HZ / 1_000_000);

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_CMD  = 4'b0010,
      ST_DATA = 4'b0100,
      ST_HOLD = 4'b1000
   } dpm_state_e;

endpackage
`default_nettype wire

// File: rtl/dpm_nco.sv
`timescale 1ns/10ps
`default_nettype none
module dpm_nco #(
   parameter int unsigned W = 32
) (
   input  wire logic         clk_sys_i,
   input  wire logic         reset_i,
   input  wire logic         run_i,
   input  wire logic [W-1:0] word_i,
   output logic              clk_o
);

   logic [W-1:0] acc;

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   if (W < 2) begin : g_bad_width
      $error("dpm_nco width must be at least 2");
   end

   // Phase accumulator, parked at zero while the loop is off
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || !run_i) begin
         acc <= '0;
      end else begin
         acc <= acc + word_i;
      end
   end

   assign clk_o = acc[W-1];  // Accumulator MSB is a flop

endmodule
`default_nettype wire

// File: sim/dpm_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module dpm_host_model #(
   parameter int unsigned HALF_CYC = 6
) (
   input  wire logic clk_sys_i,
   input  wire logic dev_data_i,
   input  wire logic dev_data_oe_i,
   output logic      ser_clk_o,
   output logic      ser_data_o,
   output logic      ser_select_n_o
);
   logic rd_seen;

   // Idle: select high, serial clock parked low
   initial begin
      ser_clk_o      = 1'b0;
      ser_data_o     = 1'b0;
      ser_select_n_o = 1'b1;
      rd_seen        = 1'b0;
   end

   // ----------------------------------------------------------------
   // One frame: direction, 7 address bits, 8 data bits, MSB first
   // ----------------------------------------------------------------
   // A short nbits aborts the frame by raising select early
   task automatic xfer(input logic dir, input logic [6:0] addr, input logic [7:0] wdata,
                       input int nbits, output logic [7:0] rdata);
      logic [15:0] frame;
      frame = {dir, addr, wdata};
      rdata = 8'h00;
      @(negedge clk_sys_i);
      ser_select_n_o = 1'b0;
      repeat (4) @(negedge clk_sys_i);
      for (int i = 15; i >= 16 - nbits; i--) begin
         ser_data_o = frame[i];
         repeat (HALF_CYC) @(negedge clk_sys_i);
         // An undriven line shows the inverse of the last sample
         if (i < 8) begin
            rd_seen  = dev_data_oe_i ? dev_data_i : ~rd_seen;
            rdata[i] = rd_seen;
         end
         ser_clk_o = 1'b1;
         repeat (HALF_CYC) @(negedge clk_sys_i);
         ser_clk_o = 1'b0;
      end
      repeat (4) @(negedge clk_sys_i);
      ser_select_n_o = 1'b1;
      ser_data_o     = ~ser_data_o;  // Released line, not the last bit
      repeat (4) @(negedge clk_sys_i);
   endtask
endmodule
`default_nettype wire

// File: sim/dual_pll_mode_config_bench.sv
`timescale 1ns/10ps
`default_nettype none
module dual_pll_mode_config_bench;
   localparam int TIMEOUT_CYC = 80000;
   logic       clk_sys_i;
   logic       reset_i;
   logic       ser_clk;
   logic       ser_data;
   logic       ser_select_n;
   logic       ref_clk = 1'b0;
   logic       ref_run;
   logic       strap;
   logic       sdo;
   logic       sdo_oe;
   logic       first_clk;
   logic       first_oe;
   logic       second_clk;
   logic       second_oe;
   logic       frame_pulse;
   logic       frame_oe;
   logic       lock;
   logic [4:0] s1 [5] = '{5'h00, 5'h02, 5'h04, 5'h08, 5'h1F};
   logic [4:0] s2 [5] = '{5'h01, 5'h03, 5'h07, 5'h10, 5'h06};
   int         fail_count = 0;
   int         total_checks = 0;
   int         cyc = 0;
   int         ref_cnt = 0;
   int         n1;
   int         n2;

   dpm_core #(.REF_TIMEOUT_CYC(64)) i_dpm_core (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i), .ser_clk_i(ser_clk), .ser_data_i(ser_data),
      .ser_select_n_i(ser_select_n), .reference_clock_in_i(ref_clk), .master_strap_i(strap),
      .ser_data_o(sdo), .ser_data_oe_o(sdo_oe), .first_clock_out_o(first_clk),
      .first_clock_oe_o(first_oe), .second_clock_out_o(second_clk), .second_clock_oe_o(second_oe),
      .frame_pulse_o(frame_pulse), .frame_pulse_oe_o(frame_oe), .lock_indication_out_o(lock));

   dpm_host_model i_dpm_host_model (
      .clk_sys_i(clk_sys_i), .dev_data_i(sdo), .dev_data_oe_i(sdo_oe),
      .ser_clk_o(ser_clk), .ser_data_o(ser_data), .ser_select_n_o(ser_select_n));

   // System clock
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   // Fast reference so lock can be seen within the short timeout
   always @(negedge clk_sys_i) begin
      if (ref_run) begin
         ref_cnt <= (ref_cnt == 19) ? 0 : ref_cnt + 1;
         if (ref_cnt == 19) ref_clk <= ~ref_clk;
      end
   end

   // Cut a hang short
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == TIMEOUT_CYC) begin
         fail_count++;
         summarize();
      end
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic summarize();
      if (fail_count == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got, input int tol = 0);
      total_checks++;
      if ((tol == 0) ? (got !== exp) : ((got > exp + 16'(tol)) || (got + 16'(tol) < exp))) begin
         fail_count++;
         $display("BAD %s expected %0h seen %0h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d, input int nbits = 16);
      logic [7:0] dummy;
      i_dpm_host_model.xfer(1'b0, a, d, nbits, dummy);
   endtask

   task automatic rd_chk(input string nm, input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] v;
      i_dpm_host_model.xfer(1'b1, a, 8'h00, 16, v);
      chk(nm, {8'h00, exp}, {8'h00, v});
      chk("read_drive_release", 16'h0000, {15'h0000, sdo_oe});
   endtask

   // Rising edges of both clock outputs over a window
   task automatic measure(input int win);
      logic p1;
      logic p2;
      n1 = 0;
      n2 = 0;
      p1 = first_clk;
      p2 = second_clk;
      repeat (win) begin
         @(negedge clk_sys_i);
         if (first_clk === 1'b1 && p1 === 1'b0) n1++;
         if (second_clk === 1'b1 && p2 === 1'b0) n2++;
         p1 = first_clk;
         p2 = second_clk;
      end
   endtask

   function automatic int m_of(input logic [4:0] s);
      if (s[4] | s[3]) return 8;
      if (s[2]) return 4;
      if (s[1]) return 2;
      return 1;
   endfunction

   function automatic logic [15:0] edges(input int win, input longint hz);
      return 16'((longint'(win) * hz) / longint'(dpm_pkg::CLK_HZ));
   endfunction

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      reset_i = 1'b1;
      strap   = 1'b0;  // Slave strap
      ref_run = 1'b0;
      repeat (3) @(negedge clk_sys_i);
      reset_i = 1'b0;
      repeat (2) @(negedge clk_sys_i);
      chk("outputs_after_reset", 16'h0000,
          {8'h00, first_clk, second_clk, frame_pulse, first_oe, second_oe, frame_oe, lock, sdo_oe});
      for (int a = 0; a < 5; a++) rd_chk("reg_reset", 7'(a), 8'h00);  // Reset values
      for (int a = 0; a < 5; a++) wr(7'(a), {3'h7, 5'(a * 7 + 3)});  // Upper bits dropped
      wr(7'h05, 8'h1F);  // Unmapped write ignored
      wr(dpm_pkg::OFF_FIRST_SEL, 8'h00, 12);  // Aborted frame leaves register
      for (int a = 0; a < 5; a++) rd_chk("reg_hold", 7'(a), 8'(a * 7 + 3));  // Values held
      rd_chk("unmapped_read", 7'h05, 8'h00);  // Unmapped reads zero
      for (int b = 2; b <= 4; b++) begin
         wr(dpm_pkg::OFF_DRIVE_EN, 8'(1 << b));
         repeat (3) @(negedge clk_sys_i);
         chk("drive_enables", 16'(1 << (b - 2)), {13'h0000, frame_oe, first_oe, second_oe});
      end
      wr(dpm_pkg::OFF_MODE_LOOP1, {3'h0, dpm_pkg::MODE_HS_REVERSE, 1'b1});  // High-speed mode
      wr(dpm_pkg::OFF_MULT_LOOP2, 8'h01);  // Zero multiplier, second loop on
      wr(dpm_pkg::OFF_DRIVE_EN, 8'h1C);  // Both clock drivers on
      for (int i = 0; i < 5; i++) begin
         strap = (i == 3);  // Master strap once, high-speed ignores it
         wr(dpm_pkg::OFF_FIRST_SEL, {3'h0, s1[i]});
         wr(dpm_pkg::OFF_SECOND_SEL, {3'h0, s2[i]});
         repeat (20) @(negedge clk_sys_i);
         measure(2000);
         chk("first_hs_edges", edges(2000, m_of(s1[i]) * dpm_pkg::BASE_HS_HZ), 16'(n1), 2);
         chk("second_hs_edges", edges(2000, m_of(s2[i]) * dpm_pkg::BASE_HS_HZ), 16'(n2), 2);
      end
      strap = 1'b0;  // Slave strap
      wr(dpm_pkg::OFF_MODE_LOOP1, {3'h0, dpm_pkg::MODE_HS_REVERSE, 1'b0});
      measure(2000);
      chk("first_loop_off", 16'h0000, 16'(n1));
      chk("second_loop_on", edges(2000, 4 * dpm_pkg::BASE_HS_HZ), 16'(n2), 2);
      wr(dpm_pkg::OFF_MULT_LOOP2, 8'h00);
      measure(2000);
      chk("second_loop_off", 16'h0000, 16'(n2));
      wr(dpm_pkg::OFF_MODE_LOOP1, {3'h0, dpm_pkg::MODE_FWD_64K, 1'b1});  // Forward 64k code
      wr(dpm_pkg::OFF_MULT_LOOP2, 8'h01);
      wr(dpm_pkg::OFF_FIRST_SEL, 8'h00);  // L of one
      wr(dpm_pkg::OFF_SECOND_SEL, 8'h1F);  // L of 32
      measure(10000);
      chk("first_fwd64_edges", edges(10000, dpm_pkg::BASE_64K_HZ), 16'(n1), 2);
      chk("second_fwd64_edges", edges(10000, 32 * dpm_pkg::BASE_64K_HZ), 16'(n2), 2);
      strap = 1'b1;  // Master strap stops forward mode
      repeat (10) @(negedge clk_sys_i);
      measure(2000);
      chk("master_strap_stops", 16'h0000, 16'(n1 + n2));
      strap = 1'b0;  // Slave strap
      wr(dpm_pkg::OFF_MODE_LOOP1, {3'h0, dpm_pkg::MODE_FWD_56K, 1'b1});  // Forward 56k code
      wr(dpm_pkg::OFF_FIRST_SEL, 8'h04);  // L of five
      wr(dpm_pkg::OFF_SECOND_SEL, 8'h0F);  // L of 16
      measure(10000);
      chk("first_fwd56_edges", edges(10000, 5 * dpm_pkg::BASE_56K_HZ), 16'(n1), 2);
      chk("second_fwd56_edges", edges(10000, 16 * dpm_pkg::BASE_56K_HZ), 16'(n2), 2);
      ref_run = 1'b1;
      repeat (300) @(negedge clk_sys_i);
      chk("lock_active", 16'h0001, {15'h0000, lock});
      // Frame pulse follows the reference once it has settled
      repeat (4) begin
         do @(negedge clk_sys_i); while (ref_cnt != 10);
         chk("frame_pulse", {15'h0000, ref_clk}, {15'h0000, frame_pulse});
      end
      wr(dpm_pkg::OFF_DRIVE_EN, 8'h1F);
      repeat (20) @(negedge clk_sys_i);
      chk("lock_disabled", 16'h0000, {15'h0000, lock});
      wr(dpm_pkg::OFF_DRIVE_EN, 8'h1C);
      repeat (100) @(negedge clk_sys_i);
      chk("lock_restored", 16'h0001, {15'h0000, lock});
      ref_run = 1'b0;
      repeat (200) @(negedge clk_sys_i);
      chk("lock_lost", 16'h0000, {15'h0000, lock});
      summarize();
   end
endmodule
`default_nettype wire
